// *** sdram_cfg_pkg.sv ***
// Constants and types for SDRAM timing configuration and interrupt masking
// Function
// - The upper-lane check interrupt is raised while mask bit 1 and its flag are both set.
// - The lower-lane check interrupt is raised while mask bit 2 and its flag are both set.
// - Each masked interrupt is a level that stays up until its mask bit or its flag clears.
// - Config bits 1:0 (reset 0) select 256, 512 or 1024 columns, with code 11 reserved.
// - Config bit 2 (reset 0) selects a read latency of 2 cycles when clear and 3 when set.
// - Config bits 4:3 (reset 2h) give a row-to-column gap of 2, 3 or 4 clocks for 10, 11, 00.
// - Config bits 6:5 give a column-to-precharge gap of 1, 2, 3 or 4 clocks for 01, 10, 11, 00.
// - Config bits 8:7 (reset 2h) give a precharge-to-next gap of 1, 2, 3 or 4 clocks likewise.
// - Config bits 10:9 (reset 0) give a refresh-to-refresh gap of 15, 3 or 7 clocks.
// - After any refresh no other command may follow for at least 15 clocks.
// - The upper and lower lane check-fail flags are set on a check error of that byte lane.
// - The refresh-late flag is set when a refresh comes later than the lateness limit.
package sdram_cfg_pkg;

    // Register offsets on the microprocessor port
    localparam logic [11:0] STATUS_OFFSET = 12'h402;
    localparam logic [11:0] MASK_OFFSET = 12'h404;
    localparam logic [11:0] CONFIG_OFFSET = 12'h408;

    // Mask register fields
    localparam int MASK_REFRESH_BIT = 0;
    localparam int MASK_UPPER_BIT = 1;
    localparam int MASK_LOWER_BIT = 2;
    localparam int MASK_WIDTH = 3;
    localparam logic [2:0] MASK_RESET = 3'h0;

    // Config register fields
    localparam int COL_LSB = 0;
    localparam int CAS_BIT = 2;
    localparam int R2C_LSB = 3;
    localparam int C2P_LSB = 5;
    localparam int P2N_LSB = 7;
    localparam int R2R_LSB = 9;
    localparam int CONFIG_WIDTH = 11;
    localparam logic [1:0] COL_RESET = 2'h0;
    localparam logic CAS_RESET = 1'b0;
    localparam logic [1:0] R2C_RESET = 2'h2;
    localparam logic [1:0] C2P_RESET = 2'h1;
    localparam logic [1:0] P2N_RESET = 2'h2;
    localparam logic [1:0] R2R_RESET = 2'h0;

    // Timing counts in SDRAM clocks
    localparam logic [3:0] REFRESH_TO_ANY_CLOCKS = 4'hf;
    localparam logic [3:0] R2R_CODE00_CLOCKS = 4'hf;
    localparam logic [3:0] R2R_CODE10_CLOCKS = 4'h3;
    localparam logic [3:0] R2R_CODE11_CLOCKS = 4'h7;

    // Decoded timing toward the command sequencer
    typedef struct packed {
        logic [10:0] column_count;
        logic [1:0] read_latency;
        logic [2:0] row_to_column_gap;
        logic [2:0] column_to_precharge_gap;
        logic [2:0] precharge_to_next_gap;
        logic [3:0] refresh_to_refresh_gap;
    } timing_type;

    // Event sources, bit 0 is refresh lateness
    typedef struct packed {
        logic lower_lane_check_fail;
        logic upper_lane_check_fail;
        logic refresh_overdue;
    } event_type;

endpackage : sdram_cfg_pkg

// *** sticky_flag.sv ***
// Sticky event flag with mask gating
`timescale 1ns/100ps
`default_nettype none
module sticky_flag (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic set,
    input wire logic clear,
    input wire logic enable,
    // Result
    output var logic flag,
    output logic request
);

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clear) begin
            flag <= 1'b0;
        end
    end

    // Level request while flag and mask both set
    assign request = flag & enable;

endmodule : sticky_flag
`default_nettype wire

// *** sdram_timing_cfg.sv ***
// SDRAM geometry and timing configuration with masked interrupt request
`timescale 1ns/100ps
`default_nettype none
module sdram_timing_cfg
    import sdram_cfg_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Microprocessor register port
    input wire logic UP_CS,
    input wire logic UP_WR,
    input wire logic UP_RD,
    input wire logic [11:0] UP_ADDR,
    input wire logic [15:0] UP_WDATA,
    output var logic [15:0] UP_RDATA,
    // Events from the controller, one-cycle pulses
    input wire sdram_cfg_pkg::event_type EVENTS,
    input wire logic REFRESH_ISSUED,
    // Decoded timing and refresh spacing
    output var sdram_cfg_pkg::timing_type TIMING,
    output var logic COMMAND_HOLD,
    output var logic REFRESH_HOLD,
    // Interrupt request
    output var logic IRQ
);
    import sdram_cfg_pkg::*;

    logic [MASK_WIDTH-1:0] irq_mask;
    logic [CONFIG_WIDTH-1:0] geometry_timing;
    logic [2:0] flags;
    logic [2:0] requests;
    logic status_clear;
    logic write_mask;
    logic write_config;
    logic [15:0] next_rdata;
    logic [3:0] any_count;
    logic [3:0] ref_count;
    timing_type next_timing;

    // ------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------

    // Strobes per register
    assign write_mask = UP_CS & UP_WR & (UP_ADDR == MASK_OFFSET);
    assign write_config = UP_CS & UP_WR & (UP_ADDR == CONFIG_OFFSET);
    assign status_clear = UP_CS & UP_RD & (UP_ADDR == STATUS_OFFSET);

    // Interrupt mask register
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            irq_mask <= MASK_RESET;
        end else if (write_mask) begin
            irq_mask <= UP_WDATA[MASK_WIDTH-1:0];
        end
    end

    // Geometry and timing register
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            geometry_timing <= {R2R_RESET, P2N_RESET, C2P_RESET, R2C_RESET, CAS_RESET, COL_RESET};
        end else if (write_config) begin
            geometry_timing <= UP_WDATA[CONFIG_WIDTH-1:0];
        end
    end

    // Read data selection, unmapped and reserved bits read zero
    always_comb begin
        next_rdata = 16'h0000;
        case (UP_ADDR)
            STATUS_OFFSET: begin
                next_rdata = {13'h0000, flags};
            end
            MASK_OFFSET: begin
                next_rdata = {13'h0000, irq_mask};
            end
            CONFIG_OFFSET: begin
                next_rdata = {5'h00, geometry_timing};
            end
            default: begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    // Registered read data
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            UP_RDATA <= 16'h0000;
        end else if (UP_CS & UP_RD) begin
            UP_RDATA <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Status flags and interrupt
    // ------------------------------------------------------------

    // One flag cell per event source, cleared by status read
    genvar i;
    generate
        for (i = 0; i < MASK_WIDTH; i++) begin : g_flag
            sticky_flag u_flag (
                .clk(CLK),
                .rstn(RSTN),
                .set(EVENTS[i]),
                .clear(status_clear),
                .enable(irq_mask[i]),
                .flag(flags[i]),
                .request(requests[i])
            );
        end
    endgenerate

    // Combined level interrupt request
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |requests;
        end
    end

    // ------------------------------------------------------------
    // Timing decode
    // ------------------------------------------------------------

    // Map a gap code to clocks, code 00 means four
    function automatic logic [2:0] gap_clocks(input logic [1:0] code);
        gap_clocks = (code == 2'h0) ? 3'h4 : {1'b0, code};
    endfunction : gap_clocks

    // Decode fields into clock counts
    always_comb begin
        next_timing = '0;
        // Column count, reserved code kept at the largest size
        case (geometry_timing[COL_LSB +: 2])
            2'h0: next_timing.column_count = 11'h100;
            2'h1: next_timing.column_count = 11'h200;
            default: next_timing.column_count = 11'h400;
        endcase
        // Read latency
        next_timing.read_latency = geometry_timing[CAS_BIT] ? 2'h3 : 2'h2;
        // Row to column gap, reserved code treated as the longest
        case (geometry_timing[R2C_LSB +: 2])
            2'h2: next_timing.row_to_column_gap = 3'h2;
            2'h3: next_timing.row_to_column_gap = 3'h3;
            default: next_timing.row_to_column_gap = 3'h4;
        endcase
        next_timing.column_to_precharge_gap = gap_clocks(geometry_timing[C2P_LSB +: 2]);
        next_timing.precharge_to_next_gap = gap_clocks(geometry_timing[P2N_LSB +: 2]);
        // Refresh to refresh gap, reserved code treated as the longest
        case (geometry_timing[R2R_LSB +: 2])
            2'h2: next_timing.refresh_to_refresh_gap = R2R_CODE10_CLOCKS;
            2'h3: next_timing.refresh_to_refresh_gap = R2R_CODE11_CLOCKS;
            default: next_timing.refresh_to_refresh_gap = R2R_CODE00_CLOCKS;
        endcase
    end

    // Registered timing toward the sequencer
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            TIMING <= '0;
        end else begin
            TIMING <= next_timing;
        end
    end

    // ------------------------------------------------------------
    // Refresh spacing guards
    // ------------------------------------------------------------

    // Hold any other command for fifteen clocks after a refresh
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            any_count <= 4'h0;
            COMMAND_HOLD <= 1'b0;
        end else if (REFRESH_ISSUED) begin
            any_count <= REFRESH_TO_ANY_CLOCKS - 4'h1;
            COMMAND_HOLD <= 1'b1;
        end else if (any_count != 4'h0) begin
            any_count <= any_count - 4'h1;
            COMMAND_HOLD <= (any_count > 4'h1);
        end else begin
            COMMAND_HOLD <= 1'b0;
        end
    end

    // Hold the next refresh for the programmed gap
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ref_count <= 4'h0;
            REFRESH_HOLD <= 1'b0;
        end else if (REFRESH_ISSUED) begin
            ref_count <= TIMING.refresh_to_refresh_gap - 4'h1;
            REFRESH_HOLD <= (TIMING.refresh_to_refresh_gap > 4'h1);
        end else if (ref_count != 4'h0) begin
            ref_count <= ref_count - 4'h1;
            REFRESH_HOLD <= (ref_count > 4'h1);
        end else begin
            REFRESH_HOLD <= 1'b0;
        end
    end

endmodule : sdram_timing_cfg
`default_nettype wire

// *** sdram_event_model.sv ***
// Event and refresh pulse source standing for the rest of the controller
`timescale 1ns/100ps
`default_nettype none
module sdram_event_model
    import sdram_cfg_pkg::*;
(
    // Clock
    input wire logic clk,
    // Pulses toward the block
    output var sdram_cfg_pkg::event_type events,
    output var logic refresh_issued
);
    // Quiet until asked
    initial begin
        events = 3'h0;
        refresh_issued = 1'b0;
    end
    // One-cycle pulse: bit 0 lateness, bits 2:1 lane check failures
    task automatic pulse_event(input logic [2:0] which);
        @(posedge clk);
        events <= which;
        @(posedge clk);
        events <= 3'h0;
    endtask : pulse_event
    // One-cycle refresh command
    task automatic pulse_refresh();
        @(posedge clk);
        refresh_issued <= 1'b1;
        @(posedge clk);
        refresh_issued <= 1'b0;
    endtask : pulse_refresh
endmodule : sdram_event_model
`default_nettype wire

// *** sdram_timing_cfg_checker.sv ***
// Port assertions for the SDRAM timing configuration block
`timescale 1ns/100ps
`default_nettype none
module sdram_timing_cfg_checker
    import sdram_cfg_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Register port
    input wire logic UP_CS,
    input wire logic UP_WR,
    input wire logic UP_RD,
    input wire logic [11:0] UP_ADDR,
    input wire logic [15:0] UP_WDATA,
    input wire logic [15:0] UP_RDATA,
    // Events and results
    input wire sdram_cfg_pkg::event_type EVENTS,
    input wire logic REFRESH_ISSUED,
    input wire sdram_cfg_pkg::timing_type TIMING,
    input wire logic COMMAND_HOLD,
    input wire logic REFRESH_HOLD,
    input wire logic IRQ
);
    logic [4:0] since_ref;
    logic rd_stat, wr_mask, wr_cfg, rd_bad;
    // Access decodes
    assign rd_stat = UP_CS && UP_RD && UP_ADDR == STATUS_OFFSET;
    assign wr_mask = UP_CS && UP_WR && UP_ADDR == MASK_OFFSET;
    assign wr_cfg = UP_CS && UP_WR && UP_ADDR == CONFIG_OFFSET;
    assign rd_bad = UP_CS && UP_RD && !(UP_ADDR inside {STATUS_OFFSET, MASK_OFFSET, CONFIG_OFFSET});
    // Cycles since the last refresh, saturating
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            since_ref <= 5'h1f;
        end else if (REFRESH_ISSUED) begin
            since_ref <= 5'h0;
        end else if (since_ref != 5'h1f) begin
            since_ref <= since_ref + 5'h1;
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    chk_cmd_hold: assert property (COMMAND_HOLD == (since_ref < 5'he))
        else $error("command hold length wrong");
    chk_ref_start: assert property (REFRESH_ISSUED |=> REFRESH_HOLD)
        else $error("refresh hold not raised");
    chk_ref_spacing: assert property (
        since_ref >= {1'b0, TIMING.refresh_to_refresh_gap} - 5'h1 |-> !REFRESH_HOLD)
        else $error("refresh hold too long");
    chk_bad_read: assert property (rd_bad |=> UP_RDATA == 16'h0)
        else $error("unmapped read not zero");
    chk_rdata_stands: assert property (!(UP_CS && UP_RD) |=> $stable(UP_RDATA))
        else $error("read data changed without read");
    chk_cas_latency: assert property (wr_cfg |-> ##2
        TIMING.read_latency == ($past(UP_WDATA[2], 2) ? 2'h3 : 2'h2))
        else $error("read latency decode wrong");
    chk_col_count: assert property (wr_cfg |-> ##2 TIMING.column_count ==
        ($past(UP_WDATA[1:0], 2) == 2'h0 ? 11'h100 :
        $past(UP_WDATA[1:0], 2) == 2'h1 ? 11'h200 : 11'h400))
        else $error("column count decode wrong");
    chk_irq_rise: assert property ($rose(IRQ) |->
        $past(EVENTS, 2) != 3'h0 || $past(wr_mask, 2))
        else $error("interrupt rose without cause");
    chk_irq_clear: assert property (rd_stat && EVENTS == 3'h0 |-> ##2 !IRQ)
        else $error("interrupt kept after status clear");
    chk_mask_off: assert property (wr_mask && UP_WDATA[2:0] == 3'h0 |-> ##2 !IRQ)
        else $error("interrupt kept after mask clear");
endmodule : sdram_timing_cfg_checker
bind sdram_timing_cfg sdram_timing_cfg_checker chk (
    .CLK(CLK), .RSTN(RSTN), .UP_CS(UP_CS), .UP_WR(UP_WR), .UP_RD(UP_RD),
    .UP_ADDR(UP_ADDR), .UP_WDATA(UP_WDATA), .UP_RDATA(UP_RDATA), .EVENTS(EVENTS),
    .REFRESH_ISSUED(REFRESH_ISSUED), .TIMING(TIMING), .COMMAND_HOLD(COMMAND_HOLD),
    .REFRESH_HOLD(REFRESH_HOLD), .IRQ(IRQ)
);
`default_nettype wire

// *** sdram_timing_cfg_tb.sv ***
// Self-checking testbench for the SDRAM timing configuration block
`timescale 1ns/100ps
`default_nettype none
module sdram_timing_cfg_tb;
    import sdram_cfg_pkg::*;
    logic CLK = 1'b0, RSTN = 1'b0, UP_CS = 1'b0, UP_WR = 1'b0, UP_RD = 1'b0;
    logic [11:0] UP_ADDR = 12'h0;
    logic [15:0] UP_WDATA = 16'h0, UP_RDATA, rdata;
    event_type EVENTS;
    timing_type TIMING;
    logic REFRESH_ISSUED, COMMAND_HOLD, REFRESH_HOLD, IRQ;
    int miscompares = 0, check_count = 0;
    // Config words with one code in every field, and their decode
    logic [15:0] cfgv [4] = '{16'h0, 16'h02ad, 16'h0552, 16'h07ff};
    timing_type exp_tab [4] = '{'{11'h100, 2'h2, 3'h4, 3'h4, 3'h4, 4'hf},
        '{11'h200, 2'h3, 3'h4, 3'h1, 3'h1, 4'hf}, '{11'h400, 2'h2, 3'h2, 3'h2, 3'h2, 4'h3},
        '{11'h400, 2'h3, 3'h3, 3'h3, 3'h3, 4'h7}};
    sdram_timing_cfg dut (
        .CLK(CLK), .RSTN(RSTN), .UP_CS(UP_CS), .UP_WR(UP_WR), .UP_RD(UP_RD),
        .UP_ADDR(UP_ADDR), .UP_WDATA(UP_WDATA), .UP_RDATA(UP_RDATA), .EVENTS(EVENTS),
        .REFRESH_ISSUED(REFRESH_ISSUED), .TIMING(TIMING), .COMMAND_HOLD(COMMAND_HOLD),
        .REFRESH_HOLD(REFRESH_HOLD), .IRQ(IRQ)
    );
    sdram_event_model src (.clk(CLK), .events(EVENTS), .refresh_issued(REFRESH_ISSUED));
    // 125 MHz clock
    initial begin
        forever #4 CLK = ~CLK;
    end
    task automatic conclude();
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmp_t(input timing_type got, input timing_type exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t timing %h expected %h", $time, got, exp);
        end
    endtask : cmp_t
    // Register port cycles, taken at the edge after setup
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge CLK);
        {UP_CS, UP_WR, UP_ADDR, UP_WDATA} <= {2'b11, a, d};
        @(posedge CLK);
        {UP_CS, UP_WR} <= 2'b00;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge CLK);
        {UP_CS, UP_RD, UP_ADDR} <= {2'b11, a};
        @(posedge CLK);
        {UP_CS, UP_RD} <= 2'b00;
        #1 rdata = UP_RDATA;
    endtask : rd
    task automatic irq_is(input logic e);
        repeat (2) @(posedge CLK);
        #1 cmp({15'h0, IRQ}, {15'h0, e});
    endtask : irq_is
    task automatic s_reset();
        rd(MASK_OFFSET);
        cmp(rdata, 16'h0);
        rd(CONFIG_OFFSET);
        cmp(rdata, 16'h0130);
        cmp_t(TIMING, timing_type'{11'h100, 2'h2, 3'h2, 3'h1, 3'h2, 4'hf});
    endtask : s_reset
    task automatic s_config();
        for (int i = 0; i < 4; i++) begin
            wr(CONFIG_OFFSET, cfgv[i] | 16'hf800);
            repeat (2) @(posedge CLK);
            #1 cmp_t(TIMING, exp_tab[i]);
            rd(CONFIG_OFFSET);
            cmp(rdata, cfgv[i]);
        end
    endtask : s_config
    // Read-only status and unmapped place refuse writes
    task automatic s_refused();
        wr(12'h406, 16'hffff);
        wr(STATUS_OFFSET, 16'h0007);
        rd(12'h406);
        cmp(rdata, 16'h0);
        rd(STATUS_OFFSET);
        cmp(rdata, 16'h0);
        rd(CONFIG_OFFSET);
        cmp(rdata, 16'h07ff);
    endtask : s_refused
    task automatic s_irq();
        for (int k = 0; k < 3; k++) begin
            wr(MASK_OFFSET, 16'h1 << k);
            src.pulse_event(3'h7 ^ (3'h1 << k));
            irq_is(1'b0);
            rd(STATUS_OFFSET);
            cmp(rdata, 16'h7 ^ (16'h1 << k));
            src.pulse_event(3'h1 << k);
            irq_is(1'b1);
            irq_is(1'b1);
            wr(MASK_OFFSET, 16'h0);
            irq_is(1'b0);
            wr(MASK_OFFSET, 16'h7);
            irq_is(1'b1);
            rd(STATUS_OFFSET);
            cmp(rdata, 16'h1 << k);
            irq_is(1'b0);
        end
    endtask : s_irq
    // Event in the same edge as the clearing read keeps its flag
    task automatic s_set_wins();
        fork
            rd(STATUS_OFFSET);
            src.pulse_event(3'h2);
        join
        cmp(rdata, 16'h0);
        irq_is(1'b1);
        rd(STATUS_OFFSET);
        cmp(rdata, 16'h2);
        irq_is(1'b0);
    endtask : s_set_wins
    task automatic s_refresh(input logic [15:0] cfg, input logic [15:0] exp_rh);
        logic [15:0] ch, rh;
        ch = 16'h0;
        rh = 16'h0;
        wr(CONFIG_OFFSET, cfg);
        src.pulse_refresh();
        #1;
        repeat (20) begin
            ch += {15'h0, COMMAND_HOLD === 1'b1};
            rh += {15'h0, REFRESH_HOLD === 1'b1};
            @(posedge CLK);
            #1;
        end
        cmp(ch, 16'he);
        cmp(rh, exp_rh);
    endtask : s_refresh
    // Main sequence
    initial begin
        repeat (6) @(posedge CLK);
        RSTN <= 1'b1;
        s_reset();
        s_config();
        s_refused();
        s_irq();
        s_set_wins();
        s_refresh(16'h07ff, 16'h6);
        s_refresh(16'h0552, 16'h2);
        s_refresh(16'h0130, 16'he);
        conclude();
    end
    // Hang guard
    initial begin
        #100000;
        miscompares++;
        conclude();
    end
endmodule : sdram_timing_cfg_tb
`default_nettype wire
